// ==== rtl/iwd_pkg.sv ====
`default_nettype none

package iwd_pkg;

  // ----------------------------------------------------------------
  // Word and field layout
  // ----------------------------------------------------------------
  localparam int WORD_W      = 14;
  localparam int CLASS_LSB   = 12;
  localparam int CLASS_W     = 2;
  localparam int NIB_LSB     = 8;
  localparam int NIB_W       = 4;
  localparam int FILE_LSB    = 0;
  localparam int FILE_W      = 7;
  localparam int DEST_POS    = 7;
  localparam int BIT_LSB     = 7;
  localparam int BIT_W       = 3;
  localparam int BITOP_LSB   = 10;
  localparam int BITOP_W     = 2;
  localparam int LIT8_W      = 8;
  localparam int LIT11_W     = 11;
  localparam int GOTO_POS    = 11;
  localparam int DATA_W      = 8;

  localparam logic [FILE_W-1:0] FILE_FIRST = 7'h00;
  localparam logic [FILE_W-1:0] FILE_LAST  = 7'h7f;

  // ----------------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------------
  localparam logic [CLASS_W-1:0] CLASS_BYTE    = 2'h0;
  localparam logic [CLASS_W-1:0] CLASS_BIT     = 2'h1;
  localparam logic [CLASS_W-1:0] CLASS_CONTROL = 2'h2;
  localparam logic [CLASS_W-1:0] CLASS_LITERAL = 2'h3;

  // ----------------------------------------------------------------
  // Byte and bit operation codes
  // ----------------------------------------------------------------
  localparam logic [NIB_W-1:0] NIB_MOVE_ACC = 4'h0;
  localparam logic [NIB_W-1:0] NIB_CLEAR    = 4'h1;
  localparam logic [NIB_W-1:0] NIB_SUB      = 4'h2;
  localparam logic [NIB_W-1:0] NIB_DEC      = 4'h3;
  localparam logic [NIB_W-1:0] NIB_OR       = 4'h4;
  localparam logic [NIB_W-1:0] NIB_AND      = 4'h5;
  localparam logic [NIB_W-1:0] NIB_XOR      = 4'h6;
  localparam logic [NIB_W-1:0] NIB_ADD      = 4'h7;
  localparam logic [NIB_W-1:0] NIB_MOVE     = 4'h8;
  localparam logic [NIB_W-1:0] NIB_COMP     = 4'h9;
  localparam logic [NIB_W-1:0] NIB_INC      = 4'ha;
  localparam logic [NIB_W-1:0] NIB_DEC_SKIP = 4'hb;
  localparam logic [NIB_W-1:0] NIB_ROT_R    = 4'hc;
  localparam logic [NIB_W-1:0] NIB_ROT_L    = 4'hd;
  localparam logic [NIB_W-1:0] NIB_SWAP     = 4'he;
  localparam logic [NIB_W-1:0] NIB_INC_SKIP = 4'hf;

  localparam logic [BITOP_W-1:0] BITOP_CLEAR      = 2'h0;
  localparam logic [BITOP_W-1:0] BITOP_SET        = 2'h1;
  localparam logic [BITOP_W-1:0] BITOP_TEST_CLEAR = 2'h2;
  localparam logic [BITOP_W-1:0] BITOP_TEST_SET   = 2'h3;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  localparam int PHASES  = 4;
  localparam int PHASE_W = 2;
  localparam logic [PHASE_W-1:0] PHASE_FIRST = 2'h0;
  localparam logic [PHASE_W-1:0] PHASE_LAST  = 2'h3;

  localparam logic [WORD_W-1:0] WORD_NOP = 14'h0000;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_MOVE_ACC_TO_FILE,
    OP_CLEAR,
    OP_SUB,
    OP_DEC,
    OP_OR_ACC_WITH_FILE,
    OP_AND,
    OP_XOR,
    OP_ADD,
    OP_MOVE_FILE,
    OP_COMPLEMENT,
    OP_INC,
    OP_DECREMENT_SKIP_ZERO,
    OP_ROTATE_RIGHT_CARRY,
    OP_ROTATE_LEFT_CARRY,
    OP_SWAP,
    OP_INC_SKIP_ZERO,
    OP_BIT_CLEAR,
    OP_BIT_SET,
    OP_BIT_TEST_CLEAR,
    OP_BIT_TEST_SET,
    OP_LITERAL,
    OP_CALL,
    OP_GOTO
  } iwd_op_t;

endpackage

`default_nettype wire

// ==== rtl/iwd_qseq.sv ====
`default_nettype none

module iwd_qseq #(
  parameter int                         PHASES  = 4,
  parameter int                         PHASE_W = 2,
  parameter logic [PHASE_W-1:0]         FIRST   = 2'h0,
  parameter logic [PHASE_W-1:0]         LAST    = 2'h3
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  output logic [PHASE_W-1:0]      phase,
  output logic                    cyc_start,
  output logic                    cyc_end
);

  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  logic [PHASE_W-1:0] phase_r;
  logic [PHASE_W-1:0] phase_nxt;

  always_comb begin
    if (phase_r == LAST) begin
      phase_nxt = FIRST;
    end else begin
      phase_nxt = phase_r + PHASE_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_r <= FIRST;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign phase     = phase_r;
  assign cyc_start = (phase_r == FIRST);
  assign cyc_end   = (phase_r == LAST);

endmodule

`default_nettype wire

// ==== rtl/iwd_decoder.sv ====
`default_nettype none

module iwd_decoder (
  input  wire logic                          CLK,
  input  wire logic                          NRST,
  input  wire logic [iwd_pkg::WORD_W-1:0]    INSTR_WORD,
  input  wire logic                          COND_TRUE,
  output logic [iwd_pkg::PHASE_W-1:0]        Q_PHASE,
  output logic                               CYCLE_START,
  output logic                               CYCLE_END,
  output logic [iwd_pkg::CLASS_W-1:0]        OP_CLASS,
  output iwd_pkg::iwd_op_t                   ALU_OP,
  output logic [iwd_pkg::FILE_W-1:0]         FILE_ADDR,
  output logic                               WRITE_ACC,
  output logic                               WRITE_FILE,
  output logic [iwd_pkg::BIT_W-1:0]          BIT_SEL,
  output logic [iwd_pkg::DATA_W-1:0]         BIT_MASK,
  output logic [iwd_pkg::LIT8_W-1:0]         LITERAL8,
  output logic [iwd_pkg::LIT11_W-1:0]        LITERAL11,
  output logic                               FLAG_Z_WE,
  output logic                               FLAG_C_WE,
  output logic                               FLAG_DC_WE,
  output logic                               SKIP_CAND,
  output logic                               PC_LOAD,
  output logic                               FORCED_NOP
);

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  logic                        cyc_start;
  logic                        cyc_end;
  logic [iwd_pkg::PHASE_W-1:0] phase;

  iwd_qseq #(
    .PHASES  (iwd_pkg::PHASES),
    .PHASE_W (iwd_pkg::PHASE_W),
    .FIRST   (iwd_pkg::PHASE_FIRST),
    .LAST    (iwd_pkg::PHASE_LAST)
  ) u_qseq (
    .clk       (CLK),
    .nrst      (NRST),
    .phase     (phase),
    .cyc_start (cyc_start),
    .cyc_end   (cyc_end)
  );

  // ----------------------------------------------------------------
  // Field split
  // ----------------------------------------------------------------
  logic [iwd_pkg::WORD_W-1:0]  word;
  logic [iwd_pkg::CLASS_W-1:0] w_class;
  logic [iwd_pkg::NIB_W-1:0]   w_nib;
  logic [iwd_pkg::FILE_W-1:0]  w_file;
  logic                        w_dest;
  logic [iwd_pkg::BIT_W-1:0]   w_bit;
  logic [iwd_pkg::BITOP_W-1:0] w_bitop;
  logic                        flush;

  assign word    = flush ? iwd_pkg::WORD_NOP : INSTR_WORD;
  assign w_class = word[iwd_pkg::CLASS_LSB +: iwd_pkg::CLASS_W];
  assign w_nib   = word[iwd_pkg::NIB_LSB +: iwd_pkg::NIB_W];
  assign w_file  = word[iwd_pkg::FILE_LSB +: iwd_pkg::FILE_W];
  assign w_dest  = word[iwd_pkg::DEST_POS];
  assign w_bit   = word[iwd_pkg::BIT_LSB +: iwd_pkg::BIT_W];
  assign w_bitop = word[iwd_pkg::BITOP_LSB +: iwd_pkg::BITOP_W];

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  iwd_pkg::iwd_op_t op_nxt;
  logic             wacc_nxt;
  logic             wfile_nxt;
  logic             fz_nxt;
  logic             fc_nxt;
  logic             fdc_nxt;
  logic             skip_nxt;
  logic             pcl_nxt;

  always_comb begin
    op_nxt    = iwd_pkg::OP_NOP;
    wacc_nxt  = 1'b0;
    wfile_nxt = 1'b0;
    fz_nxt    = 1'b0;
    fc_nxt    = 1'b0;
    fdc_nxt   = 1'b0;
    skip_nxt  = 1'b0;
    pcl_nxt   = 1'b0;
    case (w_class)
      iwd_pkg::CLASS_BYTE: begin
        wacc_nxt  = ~w_dest;
        wfile_nxt = w_dest;
        case (w_nib)
          iwd_pkg::NIB_MOVE_ACC: begin
            // Low bits ignored while destination bit is clear
            if (w_dest) begin
              op_nxt = iwd_pkg::OP_MOVE_ACC_TO_FILE;
            end else begin
              op_nxt    = iwd_pkg::OP_NOP;
              wacc_nxt  = 1'b0;
            end
          end
          iwd_pkg::NIB_CLEAR: begin
            op_nxt = iwd_pkg::OP_CLEAR;
            fz_nxt = 1'b1;
          end
          iwd_pkg::NIB_SUB: begin
            op_nxt  = iwd_pkg::OP_SUB;
            fz_nxt  = 1'b1;
            fc_nxt  = 1'b1;
            fdc_nxt = 1'b1;
          end
          iwd_pkg::NIB_DEC: begin
            op_nxt = iwd_pkg::OP_DEC;
            fz_nxt = 1'b1;
          end
          iwd_pkg::NIB_OR: begin
            op_nxt = iwd_pkg::OP_OR_ACC_WITH_FILE;
            fz_nxt = 1'b1;
          end
          iwd_pkg::NIB_AND: begin
            op_nxt = iwd_pkg::OP_AND;
            fz_nxt = 1'b1;
          end
          iwd_pkg::NIB_XOR: begin
            op_nxt = iwd_pkg::OP_XOR;
            fz_nxt = 1'b1;
          end
          iwd_pkg::NIB_ADD: begin
            op_nxt  = iwd_pkg::OP_ADD;
            fz_nxt  = 1'b1;
            fc_nxt  = 1'b1;
            fdc_nxt = 1'b1;
          end
          iwd_pkg::NIB_MOVE: begin
            op_nxt = iwd_pkg::OP_MOVE_FILE;
            fz_nxt = 1'b1;
          end
          iwd_pkg::NIB_COMP: begin
            op_nxt = iwd_pkg::OP_COMPLEMENT;
            fz_nxt = 1'b1;
          end
          iwd_pkg::NIB_INC: begin
            op_nxt = iwd_pkg::OP_INC;
            fz_nxt = 1'b1;
          end
          iwd_pkg::NIB_DEC_SKIP: begin
            op_nxt   = iwd_pkg::OP_DECREMENT_SKIP_ZERO;
            skip_nxt = 1'b1;
          end
          iwd_pkg::NIB_ROT_R: begin
            op_nxt = iwd_pkg::OP_ROTATE_RIGHT_CARRY;
            fc_nxt = 1'b1;
          end
          iwd_pkg::NIB_ROT_L: begin
            op_nxt = iwd_pkg::OP_ROTATE_LEFT_CARRY;
            fc_nxt = 1'b1;
          end
          iwd_pkg::NIB_SWAP: begin
            op_nxt = iwd_pkg::OP_SWAP;
          end
          iwd_pkg::NIB_INC_SKIP: begin
            op_nxt   = iwd_pkg::OP_INC_SKIP_ZERO;
            skip_nxt = 1'b1;
          end
          default: begin
            op_nxt = iwd_pkg::OP_NOP;
          end
        endcase
      end
      iwd_pkg::CLASS_BIT: begin
        case (w_bitop)
          iwd_pkg::BITOP_CLEAR: begin
            op_nxt    = iwd_pkg::OP_BIT_CLEAR;
            wfile_nxt = 1'b1;
          end
          iwd_pkg::BITOP_SET: begin
            op_nxt    = iwd_pkg::OP_BIT_SET;
            wfile_nxt = 1'b1;
          end
          iwd_pkg::BITOP_TEST_CLEAR: begin
            op_nxt   = iwd_pkg::OP_BIT_TEST_CLEAR;
            skip_nxt = 1'b1;
          end
          default: begin
            op_nxt   = iwd_pkg::OP_BIT_TEST_SET;
            skip_nxt = 1'b1;
          end
        endcase
      end
      iwd_pkg::CLASS_CONTROL: begin
        op_nxt  = word[iwd_pkg::GOTO_POS] ? iwd_pkg::OP_GOTO : iwd_pkg::OP_CALL;
        pcl_nxt = 1'b1;
      end
      default: begin
        op_nxt   = iwd_pkg::OP_LITERAL;
        wacc_nxt = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Second-cycle flush
  // ----------------------------------------------------------------
  logic flush_r;

  assign flush = ~flush_r & ((SKIP_CAND & COND_TRUE) | PC_LOAD);

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      flush_r <= 1'b0;
    end else if (cyc_end) begin
      flush_r <= flush;
    end
  end

  // ----------------------------------------------------------------
  // Decoded outputs, loaded once per instruction cycle
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      OP_CLASS   <= iwd_pkg::CLASS_BYTE;
      ALU_OP     <= iwd_pkg::OP_NOP;
      FILE_ADDR  <= iwd_pkg::FILE_FIRST;
      WRITE_ACC  <= 1'b0;
      WRITE_FILE <= 1'b0;
      BIT_SEL    <= '0;
      BIT_MASK   <= '0;
      LITERAL8   <= '0;
      LITERAL11  <= '0;
      FLAG_Z_WE  <= 1'b0;
      FLAG_C_WE  <= 1'b0;
      FLAG_DC_WE <= 1'b0;
      SKIP_CAND  <= 1'b0;
      PC_LOAD    <= 1'b0;
      FORCED_NOP <= 1'b0;
    end else if (cyc_end) begin
      OP_CLASS   <= w_class;
      ALU_OP     <= op_nxt;
      FILE_ADDR  <= w_file;
      WRITE_ACC  <= wacc_nxt;
      WRITE_FILE <= wfile_nxt;
      BIT_SEL    <= w_bit;
      BIT_MASK   <= iwd_pkg::DATA_W'(1) << w_bit;
      LITERAL8   <= word[iwd_pkg::LIT8_W-1:0];
      LITERAL11  <= word[iwd_pkg::LIT11_W-1:0];
      FLAG_Z_WE  <= fz_nxt;
      FLAG_C_WE  <= fc_nxt;
      FLAG_DC_WE <= fdc_nxt;
      SKIP_CAND  <= skip_nxt;
      PC_LOAD    <= pcl_nxt;
      FORCED_NOP <= flush;
    end
  end

  assign Q_PHASE     = phase;
  assign CYCLE_START = cyc_start;
  assign CYCLE_END   = cyc_end;

endmodule

`default_nettype wire

// ==== verification/iwd_decoder_properties.sv ====
`default_nettype none

module iwd_decoder_properties (
  input wire logic              CLK,
  input wire logic              NRST,
  input wire logic [13:0]       INSTR_WORD,
  input wire logic              COND_TRUE,
  input wire logic              CYCLE_START,
  input wire logic              CYCLE_END,
  input wire iwd_pkg::iwd_op_t  ALU_OP,
  input wire logic [6:0]        FILE_ADDR,
  input wire logic              WRITE_ACC,
  input wire logic              WRITE_FILE,
  input wire logic [2:0]        BIT_SEL,
  input wire logic [7:0]        BIT_MASK,
  input wire logic [10:0]       LITERAL11,
  input wire logic              FLAG_Z_WE,
  input wire logic              FLAG_C_WE,
  input wire logic              SKIP_CAND,
  input wire logic              PC_LOAD,
  input wire logic              FORCED_NOP
);
  // ------------------------------------------------------------
  // Decode and timing checks
  // ------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_cycle_len;
    NRST && CYCLE_START |=> !CYCLE_START [*3] ##1 CYCLE_START;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong");

  property p_stands;
    NRST && !CYCLE_END |=> $stable(ALU_OP) && $stable(FILE_ADDR) && $stable(WRITE_FILE);
  endproperty
  a_stands: assert property (p_stands) else $error("decode changed mid cycle");

  property p_dest;
    CYCLE_END && INSTR_WORD[13:12] == 2'h0 && INSTR_WORD[11:8] > 4'h1 |=> FORCED_NOP ||
      (WRITE_FILE == $past(INSTR_WORD[7]) && WRITE_ACC == !$past(INSTR_WORD[7]));
  endproperty
  a_dest: assert property (p_dest) else $error("destination wrong");

  property p_faddr;
    CYCLE_END && !INSTR_WORD[13] |=> FORCED_NOP || FILE_ADDR == $past(INSTR_WORD[6:0]);
  endproperty
  a_faddr: assert property (p_faddr) else $error("file address wrong");

  property p_bit;
    CYCLE_END && INSTR_WORD[13:12] == 2'h1 |=> FORCED_NOP ||
      (BIT_SEL == $past(INSTR_WORD[9:7]) && BIT_MASK == (8'h01 << $past(INSTR_WORD[9:7])));
  endproperty
  a_bit: assert property (p_bit) else $error("bit select wrong");

  property p_lit;
    CYCLE_END && INSTR_WORD[13:12] == 2'h2 |=> FORCED_NOP ||
      (PC_LOAD && LITERAL11 == $past(INSTR_WORD[10:0]));
  endproperty
  a_lit: assert property (p_lit) else $error("long literal wrong");

  property p_skip;
    CYCLE_END && SKIP_CAND && COND_TRUE |=> FORCED_NOP && ALU_OP == iwd_pkg::OP_NOP
      && !WRITE_FILE && !WRITE_ACC;
  endproperty
  a_skip: assert property (p_skip) else $error("skip gave no nop");

  property p_branch;
    CYCLE_END && PC_LOAD |=> FORCED_NOP ##1 FORCED_NOP [*3];
  endproperty
  a_branch: assert property (p_branch) else $error("branch gave no nop");

  property p_single;
    CYCLE_END && !PC_LOAD && !(SKIP_CAND && COND_TRUE) |=> !FORCED_NOP;
  endproperty
  a_single: assert property (p_single) else $error("spurious nop");

  property p_flags;
    CYCLE_END && (INSTR_WORD[13:8] == 6'h04 || INSTR_WORD[13:8] == 6'h0c) |=> FORCED_NOP ||
      (FLAG_C_WE == $past(INSTR_WORD[11]) && FLAG_Z_WE == !$past(INSTR_WORD[11]));
  endproperty
  a_flags: assert property (p_flags) else $error("flag enables wrong");
endmodule

bind iwd_decoder iwd_decoder_properties i_props (
  .CLK(CLK), .NRST(NRST), .INSTR_WORD(INSTR_WORD), .COND_TRUE(COND_TRUE),
  .CYCLE_START(CYCLE_START), .CYCLE_END(CYCLE_END), .ALU_OP(ALU_OP),
  .FILE_ADDR(FILE_ADDR), .WRITE_ACC(WRITE_ACC), .WRITE_FILE(WRITE_FILE),
  .BIT_SEL(BIT_SEL), .BIT_MASK(BIT_MASK), .LITERAL11(LITERAL11), .FLAG_Z_WE(FLAG_Z_WE),
  .FLAG_C_WE(FLAG_C_WE), .SKIP_CAND(SKIP_CAND), .PC_LOAD(PC_LOAD), .FORCED_NOP(FORCED_NOP)
);

`default_nettype wire

// ==== verification/iwd_decoder_bench.sv ====
`default_nettype none

module iwd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [13:0]      w;
    iwd_pkg::iwd_op_t op;
    logic             wa;
    logic             wf;
    logic             z;
    logic             c;
  } iwd_row_t;

  logic CLK = 1'b0, NRST = 1'b0, COND_TRUE = 1'b0, CYCLE_START, CYCLE_END;
  logic WRITE_ACC, WRITE_FILE, FLAG_Z_WE, FLAG_C_WE, PC_LOAD, FORCED_NOP;
  logic SKIP_CAND, FLAG_DC_WE, e_dc, e_skip;
  logic [13:0] INSTR_WORD = 14'h0000;
  logic [1:0]  Q_PHASE, OP_CLASS;
  logic [6:0]  FILE_ADDR;
  logic [2:0]  BIT_SEL;
  logic [7:0]  BIT_MASK, LITERAL8;
  logic [10:0] LITERAL11;
  iwd_pkg::iwd_op_t ALU_OP;
  int mismatches = 0, checks_done = 0, n;
  iwd_row_t rows [12] = '{
    '{14'h1005, iwd_pkg::OP_BIT_CLEAR, 1'b0, 1'b1, 1'b0, 1'b0},
    '{14'h1f85, iwd_pkg::OP_BIT_TEST_SET, 1'b0, 1'b0, 1'b0, 1'b0},
    '{14'h0285, iwd_pkg::OP_SUB, 1'b0, 1'b1, 1'b1, 1'b1},
    '{14'h0e05, iwd_pkg::OP_SWAP, 1'b1, 1'b0, 1'b0, 1'b0},
    '{14'h0485, iwd_pkg::OP_OR_ACC_WITH_FILE, 1'b0, 1'b1, 1'b1, 1'b0},
    '{14'h047f, iwd_pkg::OP_OR_ACC_WITH_FILE, 1'b1, 1'b0, 1'b1, 1'b0},
    '{14'h0c80, iwd_pkg::OP_ROTATE_RIGHT_CARRY, 1'b0, 1'b1, 1'b0, 1'b1},
    '{14'h0c7f, iwd_pkg::OP_ROTATE_RIGHT_CARRY, 1'b1, 1'b0, 1'b0, 1'b1},
    '{14'h0b85, iwd_pkg::OP_DECREMENT_SKIP_ZERO, 1'b0, 1'b1, 1'b0, 1'b0},
    '{14'h07aa, iwd_pkg::OP_ADD, 1'b0, 1'b1, 1'b1, 1'b1},
    '{14'h1792, iwd_pkg::OP_BIT_SET, 1'b0, 1'b1, 1'b0, 1'b0},
    '{14'h30a5, iwd_pkg::OP_LITERAL, 1'b1, 1'b0, 1'b0, 1'b0}};

  iwd_decoder i_dut (.CLK(CLK), .NRST(NRST), .INSTR_WORD(INSTR_WORD), .COND_TRUE(COND_TRUE),
    .Q_PHASE(Q_PHASE), .CYCLE_START(CYCLE_START), .CYCLE_END(CYCLE_END), .OP_CLASS(OP_CLASS),
    .ALU_OP(ALU_OP), .FILE_ADDR(FILE_ADDR), .WRITE_ACC(WRITE_ACC), .WRITE_FILE(WRITE_FILE),
    .BIT_SEL(BIT_SEL), .BIT_MASK(BIT_MASK), .LITERAL8(LITERAL8), .LITERAL11(LITERAL11),
    .FLAG_Z_WE(FLAG_Z_WE), .FLAG_C_WE(FLAG_C_WE), .FLAG_DC_WE(FLAG_DC_WE), .SKIP_CAND(SKIP_CAND),
    .PC_LOAD(PC_LOAD), .FORCED_NOP(FORCED_NOP));

  // ------------------------------------------------------------
  // Clock, checks and word issue
  // ------------------------------------------------------------
  initial begin
    forever #10 CLK = ~CLK;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Present word in phase 3, then look at phase 0
  task automatic issue(input logic [13:0] w, input logic c);
    int k = 0;
    while (Q_PHASE !== 2'h2 && k < 8) begin
      @(negedge CLK);
      k++;
    end
    if (k == 8) begin
      mismatches++;
      report_and_stop();
    end
    @(posedge CLK);
    INSTR_WORD <= w;
    COND_TRUE <= c;
    @(posedge CLK);
    @(negedge CLK);
  endtask

  task automatic chk_op(input iwd_pkg::iwd_op_t e, input logic nop);
    chk("op", 16'(e), 16'(ALU_OP));
    chk("nop", 16'(nop), 16'(FORCED_NOP));
  endtask

  initial begin
    repeat (9) @(posedge CLK);
    @(negedge CLK);
    chk("rphase", 16'h0, 16'(Q_PHASE));
    chk_op(iwd_pkg::OP_NOP, 1'b0);
    @(posedge CLK);
    NRST <= 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].w, 1'b0);
      e_dc = rows[i].op inside {iwd_pkg::OP_ADD, iwd_pkg::OP_SUB};
      e_skip = rows[i].op inside {iwd_pkg::OP_DECREMENT_SKIP_ZERO, iwd_pkg::OP_BIT_TEST_SET};
      chk_op(rows[i].op, 1'b0);
      chk("class", 16'(rows[i].w[13:12]), 16'(OP_CLASS));
      chk("wacc", 16'(rows[i].wa), 16'(WRITE_ACC));
      chk("wfile", 16'(rows[i].wf), 16'(WRITE_FILE));
      chk("zwe", 16'(rows[i].z), 16'(FLAG_Z_WE));
      chk("cwe", 16'(rows[i].c), 16'(FLAG_C_WE));
      chk("dcwe", 16'(e_dc), 16'(FLAG_DC_WE));
      chk("skip", 16'(e_skip), 16'(SKIP_CAND));
      chk("faddr", 16'(rows[i].w[6:0]), 16'(FILE_ADDR));
      if (rows[i].w[13:12] == 2'h1) begin
        chk("bsel", 16'(rows[i].w[9:7]), 16'(BIT_SEL));
        chk("mask", 16'(8'h01 << rows[i].w[9:7]), 16'(BIT_MASK));
      end
      if (rows[i].w[13:12] == 2'h3) chk("lit8", 16'(rows[i].w[7:0]), 16'(LITERAL8));
    end
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (CYCLE_START !== 1'b1 && n < 9);
    chk("period", 16'h4, 16'(n));
    issue(14'h0b85, 1'b0);
    issue(14'h0485, 1'b1);
    chk_op(iwd_pkg::OP_NOP, 1'b1);
    chk("nopwf", 16'h0, 16'(WRITE_FILE));
    issue(14'h0485, 1'b1);
    chk_op(iwd_pkg::OP_OR_ACC_WITH_FILE, 1'b0);
    issue(14'h2abc, 1'b1);
    chk_op(iwd_pkg::OP_GOTO, 1'b0);
    chk("lit11", 16'h02bc, 16'(LITERAL11));
    issue(14'h2123, 1'b0);
    chk_op(iwd_pkg::OP_NOP, 1'b1);
    issue(14'h2123, 1'b0);
    chk_op(iwd_pkg::OP_CALL, 1'b0);
    chk("pcld", 16'h1, 16'(PC_LOAD));
    issue(14'h0000, 1'b0);
    chk_op(iwd_pkg::OP_NOP, 1'b1);
    foreach (rows[i]) begin
      issue(i[0] ? 14'h017f : 14'h0100, 1'b0);
      chk_op(iwd_pkg::OP_CLEAR, 1'b0);
      chk("clracc", 16'h1, 16'(WRITE_ACC));
      issue(i[0] ? 14'h0060 : 14'h0000, 1'b0);
      chk_op(iwd_pkg::OP_NOP, 1'b0);
    end
    issue(14'h0485, 1'b0);
    @(posedge CLK);
    NRST <= 1'b0;
    @(posedge CLK);
    NRST <= 1'b1;
    @(negedge CLK);
    chk("mphase", 16'h0, 16'(Q_PHASE));
    chk_op(iwd_pkg::OP_NOP, 1'b0);
    issue(14'h0c80, 1'b0);
    chk_op(iwd_pkg::OP_ROTATE_RIGHT_CARRY, 1'b0);
    report_and_stop();
  end
endmodule

`default_nettype wire
